// ---- inc/accj_pkg.sv ----
// Constants, codes and register map of the accumulator accumulator_arith_op/compare/jump block.
// Assumes a 32-bit classic Wishbone slave port with byte addresses.
package accj_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADR_W  = 8;

  // Register byte offsets
  localparam logic [7:0] ADR_CMD_HEAD  = 8'h00;
  localparam logic [7:0] ADR_CMD_VALUE = 8'h04;
  localparam logic [7:0] ADR_CMD_CHECK = 8'h08;
  localparam logic [7:0] ADR_CTRL      = 8'h0C;
  localparam logic [7:0] ADR_STATUS    = 8'h10;
  localparam logic [7:0] ADR_ACC       = 8'h14;
  localparam logic [7:0] ADR_PC        = 8'h18;
  localparam logic [7:0] ADR_RPL_HEAD  = 8'h1C;
  localparam logic [7:0] ADR_RPL_VALUE = 8'h20;
  localparam logic [7:0] ADR_RPL_CHECK = 8'h24;

  // Byte positions inside the head words
  localparam int unsigned HEAD_B3 = 24;
  localparam int unsigned HEAD_B2 = 16;
  localparam int unsigned HEAD_B1 = 8;
  localparam int unsigned HEAD_B0 = 0;

  // Control and status bits
  localparam int unsigned CTRL_GO_BIT   = 0;
  localparam int unsigned CTRL_PROG_BIT = 1;
  localparam int unsigned CTRL_HOST_LSB = 8;
  localparam int unsigned STAT_DONE     = 0;
  localparam int unsigned STAT_ZERO     = 1;
  localparam int unsigned STAT_SAME     = 2;
  localparam int unsigned STAT_ABOVE    = 3;
  localparam int unsigned STAT_BELOW    = 4;
  localparam int unsigned STAT_SUMERR   = 5;
  localparam int unsigned STAT_DIVZ     = 6;
  localparam int unsigned STAT_BUSY     = 7;
  localparam int unsigned STAT_ERR_LSB  = 8;

  localparam logic [7:0] HOST_ADDR_RST = 8'h02;

  // Instruction codes
  localparam logic [7:0] INS_INPUT_READ = 8'h0F;
  localparam logic [7:0] INS_ARITH      = 8'h13;
  localparam logic [7:0] INS_COMPARE    = 8'h14;
  localparam logic [7:0] INS_BRANCH     = 8'h15;

  // Calculate operation types
  localparam logic [7:0] OP_ADD  = 8'h00;
  localparam logic [7:0] OP_SUB  = 8'h01;
  localparam logic [7:0] OP_MUL  = 8'h02;
  localparam logic [7:0] OP_DIV  = 8'h03;
  localparam logic [7:0] OP_MOD  = 8'h04;
  localparam logic [7:0] OP_AND  = 8'h05;
  localparam logic [7:0] OP_OR   = 8'h06;
  localparam logic [7:0] OP_XOR  = 8'h07;
  localparam logic [7:0] OP_NOT  = 8'h08;
  localparam logic [7:0] OP_LOAD = 8'h09;

  // Branch condition types
  localparam logic [7:0] null_result_cond    = 8'h00;
  localparam logic [7:0] nonnull_result_cond = 8'h01;
  localparam logic [7:0] cond_same           = 8'h02;
  localparam logic [7:0] cond_differs        = 8'h03;
  localparam logic [7:0] cond_above          = 8'h04;
  localparam logic [7:0] cond_above_or_same  = 8'h05;
  localparam logic [7:0] cond_below          = 8'h06;
  localparam logic [7:0] cond_below_or_same  = 8'h07;
  localparam logic [7:0] cond_timeout        = 8'h08;
  localparam logic [7:0] cond_alarm          = 8'h09;
  localparam logic [7:0] cond_deviation      = 8'h0A;
  localparam logic [7:0] cond_position       = 8'h0B;

  // Reply status codes
  localparam logic [7:0] RPL_OK      = 8'h64;
  localparam logic [7:0] RPL_BAD_SUM = 8'h01;
  localparam logic [7:0] RPL_BAD_CMD = 8'h02;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_EXEC  = 2'b01,
    ST_REPLY = 2'b11
  } accj_state_t;
endpackage

// ---- inc/accj_alu_if.sv ----
// Operand and result bundle between the command core and the calculate unit.
// Assumes both ends run combinationally in one clock domain.
`timescale 1ns/10ps
interface accj_alu_if #(parameter int unsigned W = 32);
  logic        [7:0]   op;
  logic signed [W-1:0] acc;
  logic signed [W-1:0] operand;
  logic signed [W-1:0] result;
  logic                div_zero;
  modport alu  (input op, acc, operand, output result, div_zero);
  modport core (output op, acc, operand, input result, div_zero);
endinterface

// ---- rtl/accj_alu.sv ----
// Combinational calculate unit: ten accumulator operations.
// Assumes the core registers the result; no state of its own.
`timescale 1ns/10ps
module accj_alu
  import accj_pkg::*;
(
  // Operands and result
  accj_alu_if.alu a
);
  always_comb begin
    a.div_zero = 1'b0;
    case (a.op)
      OP_ADD:  a.result = a.acc + a.operand;
      OP_SUB:  a.result = a.acc - a.operand;
      OP_MUL:  a.result = a.acc * a.operand;
      OP_DIV, OP_MOD: begin
        // Divide by zero would be undefined; keep the accumulator
        if (a.operand == '0) begin
          a.result   = a.acc;
          a.div_zero = 1'b1;
        end else if (a.op == OP_DIV) begin
          a.result = a.acc / a.operand;
        end else begin
          a.result = a.acc % a.operand;
        end
      end
      OP_AND:  a.result = a.acc & a.operand;
      OP_OR:   a.result = a.acc | a.operand;
      OP_XOR:  a.result = a.acc ^ a.operand;
      OP_NOT:  a.result = ~a.acc;
      OP_LOAD: a.result = a.operand;
      default: a.result = a.acc;
    endcase
  end
endmodule // accj_alu

// ---- rtl/accj_top.sv ----
// Command core: takes one frame from registers, runs accumulator_arith_op/compare/branch/input read,
// builds the reply frame. Assumes a classic Wishbone master and steady error inputs.
//
// The register offsets and the Wishbone slave port were decided locally.
`timescale 1ns/10ps
module accj_top
  import accj_pkg::*;
#(
  parameter int unsigned PC_W = 16
) (
  // Clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      ce_i,
  // Wishbone slave
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [accj_pkg::ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [accj_pkg::DATA_W-1:0] wb_dat_i,
  output      logic [accj_pkg::DATA_W-1:0] wb_dat_o,
  output      logic                      wb_ack_o,
  // Error conditions and input port value
  input  wire logic                      timeout_error_flag_i,
  input  wire logic                      outside_alarm_flag_i,
  input  wire logic                      deviation_error_flag_i,
  input  wire logic                      position_error_flag_i,
  input  wire logic [accj_pkg::DATA_W-1:0] input_value_i,
  // Program position and activity
  output      logic [PC_W-1:0]           pc_o,
  output      logic                      busy_o
);
  import accj_pkg::*;

  if (PC_W < 1 || PC_W > DATA_W) begin : g_bad_pc_w
    $error("PC_W must lie between 1 and the data width");
  end

  accj_state_t               state;
  logic        [DATA_W-1:0]  cmd_head;
  logic signed [DATA_W-1:0]  cmd_value;
  logic        [7:0]         cmd_check;
  logic                      prog_mode;
  logic        [7:0]         host_addr;
  logic signed [DATA_W-1:0]  acc;
  logic        [PC_W-1:0]    pc;
  logic                      flag_zero;
  logic                      flag_same;
  logic                      flag_above;
  logic                      flag_below;
  logic                      sum_err;
  logic                      divz;
  logic                      done;
  logic        [7:0]         rpl_status;
  logic        [DATA_W-1:0]  rpl_data;
  logic        [DATA_W-1:0]  rpl_head;
  logic        [DATA_W-1:0]  rpl_value;
  logic        [7:0]         rpl_check;
  logic        [7:0]         cmd_tgt;
  logic        [7:0]         cmd_ins;
  logic        [7:0]         cmd_type;
  logic        [7:0]         cmd_sum;
  logic        [7:0]         next_rpl_sum;
  logic                      cmd_ok;
  logic                      ins_known;
  logic                      cond_true;
  logic                      wb_req;
  logic                      wr_fire;
  logic                      go;
  logic                      exec_en;
  logic        [3:0]         err_flags;
  logic        [DATA_W-1:0]  rd_mux;

  accj_alu_if #(.W(DATA_W)) alu_bus ();

  accj_alu u_alu (
    .a (alu_bus)
  );

  assign alu_bus.op      = cmd_type;
  assign alu_bus.acc     = acc;
  assign alu_bus.operand = cmd_value;

  assign cmd_tgt   = cmd_head[HEAD_B3 +: 8];
  assign cmd_ins   = cmd_head[HEAD_B2 +: 8];
  assign cmd_type  = cmd_head[HEAD_B1 +: 8];
  assign err_flags = {position_error_flag_i, deviation_error_flag_i,
                      outside_alarm_flag_i, timeout_error_flag_i};

  // Frame check: all eight bytes before the checksum, wrapping at 8 bits
  assign cmd_sum = cmd_head[HEAD_B3 +: 8] + cmd_head[HEAD_B2 +: 8]
                 + cmd_head[HEAD_B1 +: 8] + cmd_head[HEAD_B0 +: 8]
                 + cmd_value[HEAD_B3 +: 8] + cmd_value[HEAD_B2 +: 8]
                 + cmd_value[HEAD_B1 +: 8] + cmd_value[HEAD_B0 +: 8];
  assign cmd_ok  = (cmd_sum == cmd_check);

  always_comb begin
    ins_known = 1'b0;
    if (cmd_ins == INS_ARITH) begin
      ins_known = (cmd_type <= OP_LOAD);
    end else if (cmd_ins == INS_BRANCH) begin
      ins_known = (cmd_type <= cond_position);
    end else if (cmd_ins == INS_COMPARE || cmd_ins == INS_INPUT_READ) begin
      ins_known = 1'b1;
    end
  end

  // Branch condition, arithmetic ones from the last compare only
  always_comb begin
    case (cmd_type)
      null_result_cond:    cond_true = flag_zero;
      nonnull_result_cond: cond_true = !flag_zero;
      cond_same:           cond_true = flag_same;
      cond_differs:        cond_true = !flag_same;
      cond_above:          cond_true = flag_above;
      cond_above_or_same:  cond_true = flag_above || flag_same;
      cond_below:          cond_true = flag_below;
      cond_below_or_same:  cond_true = flag_below || flag_same;
      cond_timeout:        cond_true = timeout_error_flag_i;
      cond_alarm:          cond_true = outside_alarm_flag_i;
      cond_deviation:      cond_true = deviation_error_flag_i;
      cond_position:       cond_true = position_error_flag_i;
      default:             cond_true = 1'b0;
    endcase
  end

  // Wishbone: one wait state, ack registered and dropped after one cycle
  assign wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_fire = wb_req && wb_we_i;
  assign go      = wr_fire && (wb_adr_i == ADR_CTRL) && wb_sel_i[0]
                   && wb_dat_i[CTRL_GO_BIT];
  assign exec_en = ce_i && (state == ST_EXEC);

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
                                              input logic [DATA_W-1:0] new_v,
                                              input logic [3:0]        sel);
    logic [DATA_W-1:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= wb_req;
    end
  end

  always_comb begin
    if (wb_adr_i == ADR_CMD_HEAD) begin
      rd_mux = cmd_head;
    end else if (wb_adr_i == ADR_CMD_VALUE) begin
      rd_mux = cmd_value;
    end else if (wb_adr_i == ADR_CMD_CHECK) begin
      rd_mux = {{(DATA_W-8){1'b0}}, cmd_check};
    end else if (wb_adr_i == ADR_CTRL) begin
      rd_mux = '0;
      rd_mux[CTRL_PROG_BIT] = prog_mode;
      rd_mux[CTRL_HOST_LSB +: 8] = host_addr;
    end else if (wb_adr_i == ADR_STATUS) begin
      rd_mux = '0;
      rd_mux[STAT_DONE]   = done;
      rd_mux[STAT_ZERO]   = flag_zero;
      rd_mux[STAT_SAME]   = flag_same;
      rd_mux[STAT_ABOVE]  = flag_above;
      rd_mux[STAT_BELOW]  = flag_below;
      rd_mux[STAT_SUMERR] = sum_err;
      rd_mux[STAT_DIVZ]   = divz;
      rd_mux[STAT_BUSY]   = busy_o;
      rd_mux[STAT_ERR_LSB +: 4] = err_flags;
    end else if (wb_adr_i == ADR_ACC) begin
      rd_mux = acc;
    end else if (wb_adr_i == ADR_PC) begin
      rd_mux = '0;
      rd_mux[PC_W-1:0] = pc;
    end else if (wb_adr_i == ADR_RPL_HEAD) begin
      rd_mux = rpl_head;
    end else if (wb_adr_i == ADR_RPL_VALUE) begin
      rd_mux = rpl_value;
    end else if (wb_adr_i == ADR_RPL_CHECK) begin
      rd_mux = {{(DATA_W-8){1'b0}}, rpl_check};
    end else begin
      rd_mux = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (ce_i && wb_req && !wb_we_i) begin
      wb_dat_o <= rd_mux;
    end
  end

  // Frame registers are locked while a command runs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_head  <= '0;
      cmd_value <= '0;
      cmd_check <= '0;
      prog_mode <= 1'b0;
      host_addr <= HOST_ADDR_RST;
    end else if (ce_i && wr_fire && state == ST_IDLE) begin
      if (wb_adr_i == ADR_CMD_HEAD) begin
        cmd_head <= merge(cmd_head, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == ADR_CMD_VALUE) begin
        cmd_value <= merge(cmd_value, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == ADR_CMD_CHECK && wb_sel_i[0]) begin
        cmd_check <= wb_dat_i[7:0];
      end else if (wb_adr_i == ADR_CTRL) begin
        if (wb_sel_i[0]) prog_mode <= wb_dat_i[CTRL_PROG_BIT];
        if (wb_sel_i[1]) host_addr <= wb_dat_i[CTRL_HOST_LSB +: 8];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
    end else if (ce_i) begin
      case (state)
        ST_IDLE:  if (go) state <= ST_EXEC;
        ST_EXEC:  state <= ST_REPLY;
        ST_REPLY: state <= ST_IDLE;
        default:  state <= ST_IDLE;
      endcase
    end
  end

  // Accumulator: command result wins over a software write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc <= '0;
    end else if (exec_en && cmd_ok && ins_known) begin
      if (cmd_ins == INS_ARITH) begin
        acc <= alu_bus.result;
      end else if (cmd_ins == INS_INPUT_READ && prog_mode) begin
        acc <= input_value_i;
      end
    end else if (ce_i && wr_fire && state == ST_IDLE && wb_adr_i == ADR_ACC) begin
      acc <= merge(acc, wb_dat_i, wb_sel_i);
    end
  end

  // Flags change only on compare, so branches see the latest comparison
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_zero  <= 1'b0;
      flag_same  <= 1'b0;
      flag_above <= 1'b0;
      flag_below <= 1'b0;
    end else if (exec_en && cmd_ok && cmd_ins == INS_COMPARE) begin
      flag_zero  <= (acc - cmd_value) == '0;
      flag_same  <= acc == cmd_value;
      flag_above <= acc > cmd_value;
      flag_below <= acc < cmd_value;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc <= '0;
    end else if (exec_en && cmd_ok && ins_known) begin
      if (cmd_ins == INS_BRANCH && cond_true) begin
        pc <= cmd_value[PC_W-1:0];
      end else if (prog_mode) begin
        pc <= pc + 1'b1;
      end
    end else if (ce_i && wr_fire && state == ST_IDLE && wb_adr_i == ADR_PC) begin
      pc <= wb_dat_i[PC_W-1:0];
    end
  end

  // Result status and value, kept for the reply build
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rpl_status <= '0;
      rpl_data   <= '0;
      sum_err    <= 1'b0;
      divz       <= 1'b0;
    end else if (exec_en) begin
      sum_err <= !cmd_ok;
      divz    <= cmd_ok && cmd_ins == INS_ARITH && alu_bus.div_zero;
      if (!cmd_ok) begin
        rpl_status <= RPL_BAD_SUM;
      end else if (!ins_known) begin
        rpl_status <= RPL_BAD_CMD;
      end else begin
        rpl_status <= RPL_OK;
      end
      rpl_data <= (cmd_ins == INS_INPUT_READ) ? input_value_i : cmd_value;
    end
  end

  assign next_rpl_sum = host_addr + cmd_tgt + rpl_status + cmd_ins
                      + rpl_data[HEAD_B3 +: 8] + rpl_data[HEAD_B2 +: 8]
                      + rpl_data[HEAD_B1 +: 8] + rpl_data[HEAD_B0 +: 8];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rpl_head  <= '0;
      rpl_value <= '0;
      rpl_check <= '0;
    end else if (ce_i && state == ST_REPLY) begin
      rpl_head  <= {host_addr, cmd_tgt, rpl_status, cmd_ins};
      rpl_value <= rpl_data;
      rpl_check <= next_rpl_sum;
    end
  end

  // Done set by reply build; go only lands in idle so they never meet
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done <= 1'b0;
    end else if (ce_i && state == ST_REPLY) begin
      done <= 1'b1;
    end else if (ce_i && go && state == ST_IDLE) begin
      done <= 1'b0;
    end
  end

  assign pc_o   = pc;
  assign busy_o = (state != ST_IDLE);

  accumulator_arith_op_add_a: assert property (@(posedge clk_i) disable iff (rst_i)
    exec_en && cmd_ok && cmd_ins == INS_ARITH && cmd_type == OP_ADD
    |=> acc == $past(acc) + $past(cmd_value))
    else $error("add result wrong");
  accumulator_arith_op_not_a: assert property (@(posedge clk_i) disable iff (rst_i)
    exec_en && cmd_ok && cmd_ins == INS_ARITH && cmd_type == OP_NOT
    |=> acc == ~$past(acc))
    else $error("invert result wrong");
  accumulator_arith_op_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    exec_en && cmd_ok && cmd_ins == INS_ARITH && cmd_type == OP_LOAD
    |=> acc == $past(cmd_value))
    else $error("load result wrong");
  accumulator_arith_op_reply_a: assert property (@(posedge clk_i) disable iff (rst_i)
    exec_en && cmd_ok && cmd_ins == INS_ARITH && cmd_type <= OP_LOAD ##1 ce_i
    |=> rpl_head[HEAD_B1 +: 8] == RPL_OK && done)
    else $error("calculate reply status not success");
  reply_sum_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && state == ST_REPLY |=> rpl_check == rpl_head[31:24] + rpl_head[23:16]
      + rpl_head[15:8] + rpl_head[7:0] + rpl_value[31:24] + rpl_value[23:16]
      + rpl_value[15:8] + rpl_value[7:0])
    else $error("reply checksum mismatch");
  cmp_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    exec_en && cmd_ins == INS_COMPARE |=> $stable(acc))
    else $error("compare changed accumulator");
  cmp_flags_a: assert property (@(posedge clk_i) disable iff (rst_i)
    exec_en && cmd_ok && cmd_ins == INS_COMPARE
    |=> flag_below == ($past(acc) < $past(cmd_value)) && flag_same == ($past(acc) == $past(cmd_value)))
    else $error("compare flags wrong");
  jump_take_a: assert property (@(posedge clk_i) disable iff (rst_i)
    exec_en && cmd_ok && cmd_ins == INS_BRANCH && cmd_type <= cond_position && cond_true
    |=> pc == $past(cmd_value[PC_W-1:0]))
    else $error("taken branch missed target");
  jump_skip_a: assert property (@(posedge clk_i) disable iff (rst_i)
    exec_en && cmd_ok && prog_mode && cmd_ins == INS_BRANCH && !cond_true
    |=> pc == $past(pc) + 1'b1)
    else $error("untaken branch did not step");
  err_cond_a: assert property (@(posedge clk_i) disable iff (rst_i)
    exec_en && cmd_ok && cmd_ins == INS_BRANCH && cmd_type == cond_deviation
    && deviation_error_flag_i |=> pc == $past(cmd_value[PC_W-1:0]))
    else $error("deviation branch not taken");
endmodule // accj_top

// ---- test/accj_host.sv ----
// Wishbone master model standing in for the host that issues frames.
// Assumes a classic slave that answers each request with one ack pulse.
`timescale 1ns/10ps
module accj_host (
  // Bus answer
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  // Bus request
  output      logic        cyc_o,
  output      logic        we_o,
  output      logic [7:0]  adr_o,
  output      logic [31:0] dat_o
);
  initial begin
    cyc_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 8'h00;
    dat_o = 32'h0;
  end
  // Held until ack is seen at an edge; released data inverted so stale values never match
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    dat_o <= d;
    // Only the bench watchdog ends a wait
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    we_o  <= 1'b0;
    dat_o <= ~d;
  endtask
endmodule // accj_host

// ---- test/tb_accj_top.sv ----
// Self-checking bench: frames over Wishbone, checks accumulator, flags, PC, reply.
// Assumes the bus model in accj_host and the register map of accj_pkg.
`timescale 1ns/10ps
module tb_accj_top;
  import accj_pkg::*;
  logic               clk_i = 1'b0;
  logic               rst_i = 1'b1;
  logic               cyc, we, ack, busy;
  logic [7:0]         adr;
  logic [31:0]        wdat, rdat, q, p;
  logic [31:0]        inval = 32'h0000_012E;
  logic [3:0]         errf  = 4'h0;
  logic [15:0]        pc;
  logic signed [31:0] acc, v;
  int                 fails = 0;
  int                 checked = 0;
  always #4 clk_i = ~clk_i;
  accj_host host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .we_o(we),
                  .adr_o(adr), .dat_o(wdat));
  accj_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .timeout_error_flag_i(errf[0]), .outside_alarm_flag_i(errf[1]),
    .deviation_error_flag_i(errf[2]), .position_error_flag_i(errf[3]),
    .input_value_i(inval), .pc_o(pc), .busy_o(busy));
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    host.xfer(1'b0, a, 32'h0, d);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q);
  endtask
  function automatic logic [7:0] sum8(input logic [63:0] f);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 8; i++) s += f[i*8 +: 8];
    return s;
  endfunction
  task run(input logic [7:0] ins, input logic [7:0] ty, input logic [31:0] d,
           input logic pm, input logic bad);
    wr(ADR_CMD_HEAD, {8'h01, ins, ty, 8'h00});
    wr(ADR_CMD_VALUE, d);
    wr(ADR_CMD_CHECK, {24'h0, sum8({8'h01, ins, ty, 8'h00, d}) ^ {7'h0, bad}});
    wr(ADR_CTRL, {16'h0, HOST_ADDR_RST, 6'h0, pm, 1'b1});
    // Command still in flight half a cycle after the go write
    @(negedge clk_i);
    cmp({31'h0, busy}, 32'h1);
    do rd(ADR_STATUS, q); while (q[STAT_DONE] !== 1'b1);
    cmp({31'h0, busy}, 32'h0);
  endtask
  task chk_rpl(input logic [7:0] ins, input logic [31:0] d);
    rd(ADR_RPL_HEAD, q);
    cmp(q, {HOST_ADDR_RST, 8'h01, RPL_OK, ins});
    rd(ADR_RPL_VALUE, q);
    cmp(q, d);
    rd(ADR_RPL_CHECK, q);
    cmp(q, {24'h0, sum8({HOST_ADDR_RST, 8'h01, RPL_OK, ins, d})});
  endtask
  task t_accumulator_arith_op;
    logic signed [31:0] opv [10];
    opv = '{32'd100, 32'hFFFF_EC78, 32'd7, 32'hFFFF_FFFD, 32'd9,
            32'h0F0F, 32'h3000, 32'hFFFF, 32'h0, 32'hFFFF_FFF0};
    acc = 32'sd0;
    for (int i = 0; i < 10; i++) begin
      v = opv[i];
      case (i)
        0: acc = acc + v;
        1: acc = acc - v;
        2: acc = acc * v;
        3: acc = acc / v;
        4: acc = acc % v;
        5: acc = acc & v;
        6: acc = acc | v;
        7: acc = acc ^ v;
        8: acc = ~acc;
        default: acc = v;
      endcase
      run(INS_ARITH, 8'(i), v, 1'b0, 1'b0);
      rd(ADR_ACC, q);
      cmp(q, acc);
      chk_rpl(INS_ARITH, v);
    end
  endtask
  task t_branch;
    logic [7:0] g;
    run(INS_ARITH, OP_LOAD, 32'd5, 1'b1, 1'b0);
    for (int k = 4; k < 7; k++) begin
      run(INS_COMPARE, 8'h07, k, 1'b1, 1'b0);
      rd(ADR_ACC, q);
      cmp(q, 32'd5);
      g = {k >= 5, k > 5, k <= 5, k < 5, k != 5, k == 5, k != 5, k == 5};
      for (int c = 0; c < 8; c++) begin
        rd(ADR_PC, p);
        run(INS_BRANCH, 8'(c), 32'h40 + c, 1'b1, 1'b0);
        rd(ADR_PC, q);
        cmp(q, g[c] ? 32'h40 + c : p + 1);
        cmp({16'h0, pc}, g[c] ? 32'h40 + c : p + 1);
      end
    end
  endtask
  task t_err;
    for (int f = 0; f < 4; f++) begin
      @(posedge clk_i);
      errf <= 4'h1 << f;
      for (int c = 0; c < 4; c++) begin
        wr(ADR_PC, 32'h0);
        run(INS_BRANCH, 8'(8 + c), 32'h99, 1'b1, 1'b0);
        rd(ADR_PC, q);
        cmp(q, (c == f) ? 32'h99 : 32'h1);
      end
    end
  endtask
  task t_misc;
    rd(ADR_ACC, p);
    run(INS_ARITH, OP_ADD, 32'd1, 1'b0, 1'b1);
    rd(ADR_RPL_HEAD, q);
    cmp(q, {HOST_ADDR_RST, 8'h01, RPL_BAD_SUM, INS_ARITH});
    rd(ADR_STATUS, q);
    cmp({31'h0, q[STAT_SUMERR]}, 32'h1);
    run(INS_INPUT_READ, 8'h00, 32'h0, 1'b0, 1'b0);
    rd(ADR_ACC, q);
    cmp(q, p);
    chk_rpl(INS_INPUT_READ, inval);
    run(INS_INPUT_READ, 8'h00, 32'h0, 1'b1, 1'b0);
    rd(ADR_ACC, q);
    cmp(q, inval);
    // Divide by zero keeps the accumulator and flags it
    rd(ADR_ACC, p);
    run(INS_ARITH, OP_DIV, 32'h0, 1'b0, 1'b0);
    rd(ADR_ACC, q);
    cmp(q, p);
    rd(ADR_STATUS, q);
    cmp({31'h0, q[STAT_DIVZ]}, 32'h1);
    // Type beyond the last operation is refused
    run(INS_ARITH, 8'h0A, 32'h1, 1'b0, 1'b0);
    rd(ADR_RPL_HEAD, q);
    cmp(q, {HOST_ADDR_RST, 8'h01, RPL_BAD_CMD, INS_ARITH});
    rd(ADR_ACC, q);
    cmp(q, p);
    rd(8'h3C, q);
    cmp(q, 32'h0);
  endtask
  task end_sim;
    if (fails == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ADR_CTRL, q);
    cmp(q, {16'h0, HOST_ADDR_RST, 8'h00});
    t_accumulator_arith_op;
    t_branch;
    t_err;
    t_misc;
    end_sim;
  end
  initial begin
    #400000;
    fails++;
    end_sim;
  end
endmodule // tb_accj_top
